// ### rtl/aps_top.v
// Purpose: Audio port mute source select and bit clock mode control.
// Assumes: One clock; all pins synchronous to core_clk.
// Notes:   Registers sit on an Avalon-MM slave with one wait cycle.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "aps_defs.vh"

module aps_top
#(
    parameter DIV_W = 8
)
(
    // Clock and reset.
    input wire core_clk,
    input wire arst_n,
    // Avalon-MM register slave.
    input wire [31:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Shared pins that may feed the mute inputs.
    input wire [15:0] port0_serial_data_pins,
    input wire port2_rx_high_rate_clock,
    input wire first_spi_slave_in_pin,
    input wire first_spi_chip_select_pin,
    input wire first_spi_enable_pin,
    // Mute inputs of the three audio ports.
    output wire port0_mute_in,
    output wire port1_mute_in,
    output wire port2_mute_in,
    // Transmit bit clock pin, external source and port clock.
    input wire tx_bit_clock_in,
    input wire tx_ext_clock_src,
    output wire tx_bit_clock_out,
    output wire tx_bit_clock_oe,
    output wire tx_bit_clock_core,
    // Receive bit clock pin, external source and port clock.
    input wire rx_bit_clock_in,
    input wire rx_ext_clock_src,
    output wire rx_bit_clock_out,
    output wire rx_bit_clock_oe,
    output wire rx_bit_clock_core
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    localparam SEL_NONE = 3'h0;
    localparam SEL_P0 = 3'h1;
    localparam SEL_P1 = 3'h2;
    localparam SEL_P2 = 3'h3;
    localparam SEL_CTRL = 3'h4;
    localparam SEL_DIV = 3'h5;
    localparam SEL_STAT = 3'h6;

    // Maps a byte address to a register select code.
    function [2:0] reg_decode;
        input [31:0] addr;
        begin
            case (addr)
                `APS_ADDR_PORT0_CFG: reg_decode = SEL_P0;
                `APS_ADDR_PORT1_CFG: reg_decode = SEL_P1;
                `APS_ADDR_PORT2_CFG: reg_decode = SEL_P2;
                `APS_ADDR_CLK_CTRL:  reg_decode = SEL_CTRL;
                `APS_ADDR_CLK_DIV:   reg_decode = SEL_DIV;
                `APS_ADDR_STATUS:    reg_decode = SEL_STAT;
                default:             reg_decode = SEL_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------

    reg [2:0] port0_mute_source_sel_r;
    reg [2:0] port1_mute_source_sel_r;
    reg [2:0] port2_mute_source_sel_r;
    reg [3:0] clk_ctrl_r;
    reg [DIV_W-1:0] clk_div_r;
    reg [31:0] rdata_nxt;
    wire [2:0] wr_sel;
    wire [2:0] rd_sel;
    wire wr_fire;
    wire lane0_wr;
    wire [2:0] mute_vec;
    wire [1:0] tx_mode;
    wire [1:0] rx_mode;

    assign wr_sel = reg_decode(avs_address);
    assign rd_sel = reg_decode(avs_address);

    // A write lands at the edge where the master sees waitrequest low.
    assign wr_fire = avs_write & ~avs_waitrequest;
    assign lane0_wr = wr_fire & avs_byteenable[0];

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------

    // Waitrequest idles high, drops for one cycle per request.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            avs_waitrequest <= 1'b1;
        else if ((avs_read | avs_write) & avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // Read data gathered from the register file; reserved bits are zero.
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        case (rd_sel)
            SEL_P0:
                rdata_nxt[2:0] = port0_mute_source_sel_r;
            SEL_P1:
                rdata_nxt[2:0] = port1_mute_source_sel_r;
            SEL_P2:
                rdata_nxt[2:0] = port2_mute_source_sel_r;
            SEL_CTRL:
                rdata_nxt[3:0] = clk_ctrl_r;
            SEL_DIV:
                rdata_nxt[DIV_W-1:0] = clk_div_r;
            SEL_STAT:
            begin
                rdata_nxt[`APS_STAT_MUTE_LSB+2:`APS_STAT_MUTE_LSB] =
                    mute_vec;
                rdata_nxt[`APS_STAT_TX_MODE_LSB+1:`APS_STAT_TX_MODE_LSB] =
                    tx_mode;
                rdata_nxt[`APS_STAT_RX_MODE_LSB+1:`APS_STAT_RX_MODE_LSB] =
                    rx_mode;
            end
            default:
                rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data is loaded as waitrequest drops and holds until next.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read & avs_waitrequest)
            avs_readdata <= rdata_nxt;
    end

    // ------------------------------------------------------------------
    // Mute selectors
    // ------------------------------------------------------------------

    // Only bits 2:0 are stored; upper written bits are dropped.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port0_mute_source_sel_r <= `APS_MUTE_SEL_RST;
            port1_mute_source_sel_r <= `APS_MUTE_SEL_RST;
            port2_mute_source_sel_r <= `APS_MUTE_SEL_RST;
        end
        else if (lane0_wr)
        begin
            if (wr_sel == SEL_P0)
                port0_mute_source_sel_r <= avs_writedata[2:0];
            if (wr_sel == SEL_P1)
                port1_mute_source_sel_r <= avs_writedata[2:0];
            if (wr_sel == SEL_P2)
                port2_mute_source_sel_r <= avs_writedata[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Clock control registers
    // ------------------------------------------------------------------

    // Clock mode bits and divider value.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_ctrl_r <= `APS_CLK_CTRL_RST;
            clk_div_r <= `APS_CLK_DIV_RST;
        end
        else if (lane0_wr)
        begin
            if (wr_sel == SEL_CTRL)
                clk_ctrl_r <= avs_writedata[3:0];
            if (wr_sel == SEL_DIV)
                clk_div_r <= avs_writedata[DIV_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Mute multiplexers, one per port
    // ------------------------------------------------------------------

    wire [8:0] sel_bus;
    wire [7:1] mute_src;

    // The same seven pins feed all three selectors.
    assign mute_src = {first_spi_enable_pin, first_spi_chip_select_pin,
                       first_spi_slave_in_pin, port2_rx_high_rate_clock,
                       port0_serial_data_pins[9],
                       port0_serial_data_pins[8],
                       port0_serial_data_pins[7]};
    assign sel_bus = {port2_mute_source_sel_r, port1_mute_source_sel_r,
                      port0_mute_source_sel_r};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_mute
            aps_mute_mux u_mux
            (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .mute_sel(sel_bus[3*gi+2:3*gi]),
                .src_pins(mute_src),
                .mute_r(mute_vec[gi])
            );
        end
    endgenerate

    assign port0_mute_in = mute_vec[0];
    assign port1_mute_in = mute_vec[1];
    assign port2_mute_in = mute_vec[2];

    // ------------------------------------------------------------------
    // Bit clock mode control
    // ------------------------------------------------------------------

    // Transmit bit clock.
    aps_bit_clock_ctl #(.DIV_W(DIV_W)) u_tx_clk
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .internal_sel(clk_ctrl_r[`APS_TX_INT_SEL_BIT]),
        .pin_dir(clk_ctrl_r[`APS_TX_PIN_DIR_BIT]),
        .div_val(clk_div_r),
        .pin_in(tx_bit_clock_in),
        .ext_src(tx_ext_clock_src),
        .pin_out_r(tx_bit_clock_out),
        .pin_oe_r(tx_bit_clock_oe),
        .bit_clk_r(tx_bit_clock_core),
        .mode_r(tx_mode)
    );

    // Receive bit clock.
    aps_bit_clock_ctl #(.DIV_W(DIV_W)) u_rx_clk
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .internal_sel(clk_ctrl_r[`APS_RX_INT_SEL_BIT]),
        .pin_dir(clk_ctrl_r[`APS_RX_PIN_DIR_BIT]),
        .div_val(clk_div_r),
        .pin_in(rx_bit_clock_in),
        .ext_src(rx_ext_clock_src),
        .pin_out_r(rx_bit_clock_out),
        .pin_oe_r(rx_bit_clock_oe),
        .bit_clk_r(rx_bit_clock_core),
        .mode_r(rx_mode)
    );

endmodule // aps_top

// ### rtl/aps_defs.vh
// Purpose: Shared constants for the audio port mute source select block.
// Assumes: Byte addresses on a 32-bit Avalon-MM register bus.
// Notes:   Included by its bare name from every design file.
`ifndef APS_DEFS_VH
`define APS_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define APS_ADDR_PORT0_CFG 32'h4000_0018
`define APS_ADDR_PORT1_CFG 32'h4000_001C
`define APS_ADDR_PORT2_CFG 32'h4000_0020
`define APS_ADDR_CLK_CTRL 32'h4000_0024
`define APS_ADDR_CLK_DIV 32'h4000_0028
`define APS_ADDR_STATUS 32'h4000_002C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define APS_MUTE_SEL_MSB 2
`define APS_MUTE_SEL_LSB 0
`define APS_MUTE_SEL_RST 3'h0
`define APS_TX_INT_SEL_BIT 0
`define APS_TX_PIN_DIR_BIT 1
`define APS_RX_INT_SEL_BIT 2
`define APS_RX_PIN_DIR_BIT 3
`define APS_CLK_CTRL_RST 4'h0
`define APS_CLK_DIV_RST 8'h01
`define APS_STAT_MUTE_LSB 0
`define APS_STAT_TX_MODE_LSB 4
`define APS_STAT_RX_MODE_LSB 6

// ----------------------------------------------------------------------
// Mute source codes
// ----------------------------------------------------------------------
`define APS_SRC_ZERO 3'h0
`define APS_SRC_DATA7 3'h1
`define APS_SRC_DATA8 3'h2
`define APS_SRC_DATA9 3'h3
`define APS_SRC_HRCLK 3'h4
`define APS_SRC_SPI_SI 3'h5
`define APS_SRC_SPI_CS 3'h6
`define APS_SRC_SPI_EN 3'h7

// ----------------------------------------------------------------------
// Bit clock mode codes shown in the status register
// ----------------------------------------------------------------------
`define APS_MODE_EXT_IN 2'h0
`define APS_MODE_EXT_OUT 2'h1
`define APS_MODE_INTERNAL 2'h2
`define APS_MODE_INT_NODRV 2'h3

`endif

// ### rtl/aps_mute_mux.v
// Purpose: Picks one of eight mute sources for one audio port.
// Assumes: All source pins are synchronous to core_clk.
// Notes:   The chosen level is registered, one edge after the selector.
`timescale 1ns/10ps
`include "aps_defs.vh"

module aps_mute_mux
(
    // Clock and reset.
    input wire core_clk,
    input wire arst_n,
    // Selector from the configuration register.
    input wire [2:0] mute_sel,
    // Candidate sources, ordered by code 1 to 7.
    input wire [7:1] src_pins,
    // Registered mute level for the port.
    output reg mute_r
);

    reg mute_nxt;

    // Chooses the source named by the selector code.
    always @*
    begin
        case (mute_sel)
            `APS_SRC_ZERO:   mute_nxt = 1'b0;
            `APS_SRC_DATA7:  mute_nxt = src_pins[1];
            `APS_SRC_DATA8:  mute_nxt = src_pins[2];
            `APS_SRC_DATA9:  mute_nxt = src_pins[3];
            `APS_SRC_HRCLK:  mute_nxt = src_pins[4];
            `APS_SRC_SPI_SI: mute_nxt = src_pins[5];
            `APS_SRC_SPI_CS: mute_nxt = src_pins[6];
            `APS_SRC_SPI_EN: mute_nxt = src_pins[7];
            default:         mute_nxt = 1'b0;
        endcase
    end

    // Follows the source every cycle, so a new code acts at the next edge.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            mute_r <= 1'b0;
        else
            mute_r <= mute_nxt;
    end

endmodule // aps_mute_mux

// ### rtl/aps_bit_clock_ctl.v
// Purpose: Sets the source and pin direction of one audio bit clock.
// Assumes: Pin levels are synchronous to core_clk.
// Notes:   The internal clock is core_clk divided by 2*(div_val+1).
`timescale 1ns/10ps
`include "aps_defs.vh"

module aps_bit_clock_ctl
#(
    parameter DIV_W = 8
)
(
    // Clock and reset.
    input wire core_clk,
    input wire arst_n,
    // Mode control from software.
    input wire internal_sel,
    input wire pin_dir,
    input wire [DIV_W-1:0] div_val,
    // Pin input side and external clock source.
    input wire pin_in,
    input wire ext_src,
    // Pin output side, port clock and mode.
    output reg pin_out_r,
    output reg pin_oe_r,
    output reg bit_clk_r,
    output reg [1:0] mode_r
);

    reg [DIV_W-1:0] div_cnt_r;
    reg int_clk_r;
    reg tick;
    reg pin_out_nxt;
    reg pin_oe_nxt;
    reg bit_clk_nxt;
    reg [1:0] mode_nxt;

    // Divider: one-cycle enable pulse at each half period.
    always @*
    begin
        tick = (div_cnt_r == div_val);
    end

    // Counter and internally generated clock.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt_r <= {DIV_W{1'b0}};
            int_clk_r <= 1'b0;
        end
        else if (tick)
        begin
            div_cnt_r <= {DIV_W{1'b0}};
            int_clk_r <= ~int_clk_r;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // Mode decode from the clock-mode and pin-direction bits.
    always @*
    begin
        case ({internal_sel, pin_dir})
            2'b11:
            begin
                mode_nxt = `APS_MODE_INTERNAL;
                bit_clk_nxt = int_clk_r;
                pin_out_nxt = int_clk_r;
                pin_oe_nxt = 1'b1;
            end
            2'b00:
            begin
                mode_nxt = `APS_MODE_EXT_IN;
                bit_clk_nxt = pin_in;
                pin_out_nxt = 1'b0;
                pin_oe_nxt = 1'b0;
            end
            2'b01:
            begin
                mode_nxt = `APS_MODE_EXT_OUT;
                bit_clk_nxt = ext_src;
                pin_out_nxt = ext_src;
                pin_oe_nxt = 1'b1;
            end
            default:
            begin
                // Internal clock kept inside; the pin is left undriven.
                mode_nxt = `APS_MODE_INT_NODRV;
                bit_clk_nxt = int_clk_r;
                pin_out_nxt = 1'b0;
                pin_oe_nxt = 1'b0;
            end
        endcase
    end

    // Registers every output.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            bit_clk_r <= 1'b0;
            mode_r <= `APS_MODE_EXT_IN;
        end
        else
        begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            bit_clk_r <= bit_clk_nxt;
            mode_r <= mode_nxt;
        end
    end

endmodule // aps_bit_clock_ctl

// ### verification/aps_top_assertions.sv
// Purpose: Port-level checks of the mute select block.
// Assumes: One clock; reset is asynchronous and active low.
// Notes:   Shadows register writes to predict the outputs.
`timescale 1ns/10ps
`include "aps_defs.vh"

module aps_chk
(
    // Clock, reset and register bus.
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Mute sources and levels.
    input wire logic [15:0] port0_serial_data_pins,
    input wire logic port2_rx_high_rate_clock,
    input wire logic first_spi_slave_in_pin,
    input wire logic first_spi_chip_select_pin,
    input wire logic first_spi_enable_pin,
    input wire logic port0_mute_in,
    input wire logic port1_mute_in,
    input wire logic port2_mute_in,
    // Bit clock pins.
    input wire logic tx_bit_clock_in,
    input wire logic tx_bit_clock_oe,
    input wire logic tx_bit_clock_core,
    input wire logic rx_ext_clock_src,
    input wire logic rx_bit_clock_out,
    input wire logic rx_bit_clock_oe
);
    logic [2:0] sh0_r, sh1_r, sh2_r;
    logic [3:0] ctl_r;
    wire wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
    // Candidate sources indexed by selector code.
    wire [7:0] src_v = {first_spi_enable_pin, first_spi_chip_select_pin,
        first_spi_slave_in_pin, port2_rx_high_rate_clock,
        port0_serial_data_pins[9:7], 1'b0};

    // Mirrors each selector and clock-control write at the edge that completes it.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sh0_r <= 3'h0;
            sh1_r <= 3'h0;
            sh2_r <= 3'h0;
            ctl_r <= 4'h0;
        end
        else if (wr_ok)
        begin
            if (avs_address == `APS_ADDR_PORT0_CFG) sh0_r <= avs_writedata[2:0];
            if (avs_address == `APS_ADDR_PORT1_CFG) sh1_r <= avs_writedata[2:0];
            if (avs_address == `APS_ADDR_PORT2_CFG) sh2_r <= avs_writedata[2:0];
            if (avs_address == `APS_ADDR_CLK_CTRL) ctl_r <= avs_writedata[3:0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence taken_s;
        (avs_read | avs_write) & avs_waitrequest;
    endsequence
    sequence answer_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("bus answer is not one cycle");
    idle_wait_a: assert property (!(avs_read | avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    read_sel_a: assert property (avs_read && avs_waitrequest
        && avs_address == `APS_ADDR_PORT1_CFG
        |=> avs_readdata == {29'h0, $past(sh1_r)})
        else $error("selector readback wrong");
    mute_zero_a: assert property (1'b1 |=> port0_mute_in == $past(src_v[sh0_r]))
        else $error("port zero mute source wrong");
    mute_one_a: assert property (1'b1 |=> port1_mute_in == $past(src_v[sh1_r]))
        else $error("port one mute source wrong");
    mute_two_a: assert property (1'b1 |=> port2_mute_in == $past(src_v[sh2_r]))
        else $error("port two mute source wrong");
    tx_drive_a: assert property (1'b1 |=> tx_bit_clock_oe == $past(ctl_r[1]))
        else $error("transmit pin enable wrong");
    rx_drive_a: assert property (1'b1 |=> rx_bit_clock_oe == $past(ctl_r[3]))
        else $error("receive pin enable wrong");
    tx_ext_in_a: assert property (ctl_r[1:0] == 2'b00
        |=> tx_bit_clock_core == $past(tx_bit_clock_in))
        else $error("transmit clock not taken from pin");
    rx_ext_out_a: assert property (ctl_r[3:2] == 2'b10
        |=> rx_bit_clock_out == $past(rx_ext_clock_src))
        else $error("receive pin not driven from source");
endmodule // aps_chk

bind aps_top aps_chk aps_chk_i (.core_clk(core_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port0_serial_data_pins(port0_serial_data_pins),
    .port2_rx_high_rate_clock(port2_rx_high_rate_clock),
    .first_spi_slave_in_pin(first_spi_slave_in_pin),
    .first_spi_chip_select_pin(first_spi_chip_select_pin),
    .first_spi_enable_pin(first_spi_enable_pin),
    .port0_mute_in(port0_mute_in), .port1_mute_in(port1_mute_in),
    .port2_mute_in(port2_mute_in), .tx_bit_clock_in(tx_bit_clock_in),
    .tx_bit_clock_oe(tx_bit_clock_oe), .tx_bit_clock_core(tx_bit_clock_core),
    .rx_ext_clock_src(rx_ext_clock_src), .rx_bit_clock_out(rx_bit_clock_out),
    .rx_bit_clock_oe(rx_bit_clock_oe));

// ### verification/aps_top_test.sv
// Purpose: Self-checking bench of the mute select block.
// Assumes: The register bus answers after one wait cycle.
// Notes:   Outputs are judged from a falling-edge snapshot.
`timescale 1ns/10ps
`include "aps_defs.vh"

module aps_top_test;
    logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest, ws_s;
    logic [31:0] avs_address, avs_writedata, avs_readdata, rd_s, q;
    logic [3:0] avs_byteenable;
    logic [15:0] port0_serial_data_pins;
    logic port2_rx_high_rate_clock, first_spi_slave_in_pin;
    logic first_spi_chip_select_pin, first_spi_enable_pin;
    logic port0_mute_in, port1_mute_in, port2_mute_in;
    logic tx_bit_clock_in, tx_ext_clock_src, tx_bit_clock_out;
    logic tx_bit_clock_oe, tx_bit_clock_core, rx_bit_clock_in;
    logic rx_ext_clock_src, rx_bit_clock_out, rx_bit_clock_oe;
    logic rx_bit_clock_core;
    logic [2:0] mu_s, tx_s, rx_s;
    int n_mismatch = 0;
    int total_checks = 0;

    aps_top aps_top_i (.core_clk(core_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .port0_serial_data_pins(port0_serial_data_pins),
        .port2_rx_high_rate_clock(port2_rx_high_rate_clock),
        .first_spi_slave_in_pin(first_spi_slave_in_pin),
        .first_spi_chip_select_pin(first_spi_chip_select_pin),
        .first_spi_enable_pin(first_spi_enable_pin),
        .port0_mute_in(port0_mute_in), .port1_mute_in(port1_mute_in),
        .port2_mute_in(port2_mute_in), .tx_bit_clock_in(tx_bit_clock_in),
        .tx_ext_clock_src(tx_ext_clock_src),
        .tx_bit_clock_out(tx_bit_clock_out),
        .tx_bit_clock_oe(tx_bit_clock_oe),
        .tx_bit_clock_core(tx_bit_clock_core),
        .rx_bit_clock_in(rx_bit_clock_in),
        .rx_ext_clock_src(rx_ext_clock_src),
        .rx_bit_clock_out(rx_bit_clock_out),
        .rx_bit_clock_oe(rx_bit_clock_oe),
        .rx_bit_clock_core(rx_bit_clock_core));

    // Free-running system clock.
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Captures settled outputs away from the rising edge.
    always @(negedge core_clk)
    begin
        ws_s = avs_waitrequest;
        rd_s = avs_readdata;
        mu_s = {port2_mute_in, port1_mute_in, port0_mute_in};
        tx_s = {tx_bit_clock_out, tx_bit_clock_oe, tx_bit_clock_core};
        rx_s = {rx_bit_clock_out, rx_bit_clock_oe, rx_bit_clock_core};
    end

    // Prints the verdict and ends the run.
    task conclude;
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Compares one value and reports a difference.
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus access, held until waitrequest is seen low.
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge core_clk);
        while (ws_s !== 1'b0 && n < 40)
        begin
            @(posedge core_clk);
            n++;
        end
        q = rd_s;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
        if (n == 40)
        begin
            n_mismatch++;
            $display("[ERR] %0t bus answer timed out", $time);
            conclude;
        end
    endtask

    // Reads a register and compares it.
    task rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(q, e);
    endtask

    // Sets every mute source; unused data pins follow bit zero.
    task drive(input logic [7:0] v);
        port0_serial_data_pins <= {{6{v[0]}}, v[3:1], {7{v[0]}}};
        port2_rx_high_rate_clock <= v[4];
        first_spi_slave_in_pin <= v[5];
        first_spi_chip_select_pin <= v[6];
        first_spi_enable_pin <= v[7];
    endtask

    // Reset values of registers and outputs.
    task t_reset;
        rd(`APS_ADDR_PORT0_CFG, 32'h0);
        rd(`APS_ADDR_PORT1_CFG, 32'h0);
        rd(`APS_ADDR_PORT2_CFG, 32'h0);
        rd(`APS_ADDR_CLK_CTRL, 32'h0);
        rd(`APS_ADDR_CLK_DIV, 32'h1);
        cmp({mu_s, tx_s[1], rx_s[1]}, 32'h0);
    endtask

    // Every selector code of one port, with its latency.
    task t_mute(input int p);
        logic [31:0] a;
        logic [7:0] pv;
        int c;
        a = `APS_ADDR_PORT0_CFG + 32'(p) * 32'h4;
        for (c = 0; c < 8; c++)
        begin
            pv = (c == 0) ? 8'hFE : (8'h01 << c);
            drive(pv);
            bus(1'b1, a, 32'(c));
            @(posedge core_clk);
            cmp(mu_s[p], 32'(c != 0));
            drive(~pv);
            repeat (2) @(posedge core_clk);
            cmp(mu_s[p], 32'h0);
            rd(a, 32'(c));
        end
    endtask

    // Masked and unmapped accesses leave the port one selector alone.
    task t_bus;
        bus(1'b1, `APS_ADDR_PORT1_CFG, 32'h5);
        avs_byteenable <= 4'h0;
        bus(1'b1, `APS_ADDR_PORT1_CFG, 32'h2);
        avs_byteenable <= 4'hF;
        bus(1'b1, `APS_ADDR_STATUS + 32'h4, 32'h3);
        rd(`APS_ADDR_PORT1_CFG, 32'h5);
        rd(`APS_ADDR_STATUS + 32'h4, 32'h0);
    endtask

    // One bit clock mode: md is pin direction then internal select.
    task t_clk(input int rx, input logic [1:0] md);
        logic [2:0] s;
        logic pr;
        int i, t;
        bus(1'b1, `APS_ADDR_CLK_CTRL, rx ? {28'h0, md, 2'h0} : {30'h0, md});
        t = md[0] ? (md[1] ? 2 : 3) : md[1];
        rd(`APS_ADDR_STATUS, 32'(t) << (rx ? 6 : 4));
        s = rx ? rx_s : tx_s;
        cmp(s[1], 32'(md[1]));
        for (i = 0; i < 8; i++)
        begin
            tx_bit_clock_in <= i[0];
            rx_bit_clock_in <= i[0];
            tx_ext_clock_src <= i[1];
            rx_ext_clock_src <= i[1];
            repeat (2) @(posedge core_clk);
            s = rx ? rx_s : tx_s;
            if (md == 2'b00) cmp(s[0], 32'(i[0]));
            if (md == 2'b10) cmp(s[2], 32'(i[1]));
        end
        t = 0;
        pr = s[0];
        for (i = 0; i < 30 && md == 2'b11; i++)
        begin
            @(posedge core_clk);
            s = rx ? rx_s : tx_s;
            t += (s[0] !== pr);
            pr = s[0];
        end
        if (md == 2'b11) cmp(32'(t), 32'hA);
    endtask

    // Reset, then every scenario in turn.
    initial
    begin
        int p, m;
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 32'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        port0_serial_data_pins = 16'h0;
        {port2_rx_high_rate_clock, first_spi_slave_in_pin} = 2'h0;
        {first_spi_chip_select_pin, first_spi_enable_pin} = 2'h0;
        {tx_bit_clock_in, tx_ext_clock_src} = 2'h0;
        {rx_bit_clock_in, rx_ext_clock_src} = 2'h0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_reset;
        for (p = 0; p < 3; p++) t_mute(p);
        t_bus;
        drive(8'h00); // Quiet sources, so status shows no mute level.
        bus(1'b1, `APS_ADDR_CLK_DIV, 32'h2);
        for (p = 0; p < 2; p++)
            for (m = 0; m < 4; m++) t_clk(p, 2'(m));
        conclude;
    end
endmodule // aps_top_test
